// ===== rtl/zqc_eng_if.sv
// interface between sequencer and calibration engine
`timescale 1ns/1ps
interface zqc_eng_if;
  import zqc_pkg::*;
  logic start;
  logic [CNT_W-1:0] run_cyc;
  logic done;
  logic [IMP_W-1:0] code;
  logic busy;
  modport seq (output start, output run_cyc, input done, input code, input busy);
  modport eng (input start, input run_cyc, output done, output code, output busy);
endinterface : zqc_eng_if

// ===== rtl/zqc_engine.sv
// calibration engine: counts run time, produces a new impedance code
`timescale 1ns/1ps
module zqc_engine
  import zqc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sequencer side
  zqc_eng_if.eng eng,
  // comparator from the resistor pad
  input wire logic cmp_hi
);

  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [IMP_W-1:0] code_r, code_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (eng.start)
    begin
      busy_nxt = 1'b1;
      cnt_nxt = eng.run_cyc;
    end
    else if (busy_r)
    begin
      // successive step towards the pad balance
      if (cmp_hi && code_r != 6'h3F)
        code_nxt = code_r + 6'h01;
      else if (!cmp_hi && code_r != 6'h00)
        code_nxt = code_r - 6'h01;
      if (cnt_r <= 12'h001)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r - 12'h001;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      code_r <= IMP_RST;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign eng.done = done_r;
  assign eng.code = code_r;
  assign eng.busy = busy_r;

endmodule // zqc_engine

// ===== rtl/zqc_pkg.sv
// package of constants and types for the impedance calibration sequencer
package zqc_pkg;

  // ****************************************
  // timing (ns) and derived cycle counts
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  // calibration windows in clock cycles
  localparam int ZQINIT_CYC_DEF = 512;
  localparam int ZQOPER_CYC_DEF = 256;
  localparam int ZQCS_CYC_DEF = 64;
  // engine run time, shorter than the window of its own command
  localparam int ENG_LONG_CYC_DEF = 200;
  localparam int ENG_SHORT_CYC_DEF = 48;
  localparam int CNT_W = 12;

  // ****************************************
  // command codes and states
  // ****************************************
  typedef enum logic [1:0] {
    ZQC_CMD_NONE = 2'h0,
    ZQC_CMD_LONG = 2'h1,
    ZQC_CMD_SHORT = 2'h2
  } zqc_cmd_t;

  typedef enum logic [1:0] {
    ZQC_IDLE = 2'h0,
    ZQC_CAL = 2'h1,
    ZQC_XFER = 2'h3,
    ZQC_WAIT = 2'h2
  } zqc_state_t;

  localparam int IMP_W = 6;
  localparam logic [5:0] IMP_RST = 6'h20;

endpackage : zqc_pkg

// ===== rtl/zqc_seq.sv
// impedance calibration sequencer inside the memory device
`timescale 1ns/1ps
module zqc_seq
  import zqc_pkg::*;
#(
  parameter int ZQINIT_CYC = ZQINIT_CYC_DEF,
  parameter int ZQOPER_CYC = ZQOPER_CYC_DEF,
  parameter int ZQCS_CYC = ZQCS_CYC_DEF,
  parameter int ENG_LONG_CYC = ENG_LONG_CYC_DEF,
  parameter int ENG_SHORT_CYC = ENG_SHORT_CYC_DEF
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // decoded command from the command decoder
  input wire zqc_cmd_t cmd,
  input wire logic dll_relock,
  input wire logic sr_exit,
  // pad comparator
  input wire logic cmp_hi,
  // IO impedance and status
  output logic [IMP_W-1:0] io_code,
  output logic zq_current_en,
  output logic cal_busy,
  output logic first_long_done
);

  zqc_eng_if eif ();

  zqc_engine u_eng (
    .core_clk(core_clk),
    .rst(rst),
    .eng(eif.eng),
    .cmp_hi(cmp_hi)
  );

  // ****************************************
  // sequencer state
  // ****************************************
  zqc_state_t st_r, st_nxt;
  logic [CNT_W-1:0] win_r, win_nxt;
  logic first_r, first_nxt;
  logic [IMP_W-1:0] io_r, io_nxt;
  logic start_nxt, start_r;
  logic [CNT_W-1:0] run_r, run_nxt;

  always_comb
  begin
    st_nxt = st_r;
    win_nxt = win_r;
    first_nxt = first_r;
    io_nxt = io_r;
    start_nxt = 1'b0;
    run_nxt = run_r;
    unique case (st_r)
      ZQC_IDLE:
      begin
        // accepted regardless of relock; self-refresh exit alone starts nothing
        if (cmd == ZQC_CMD_LONG)
        begin
          st_nxt = ZQC_CAL;
          start_nxt = 1'b1;
          run_nxt = CNT_W'(ENG_LONG_CYC);
          win_nxt = first_r ? CNT_W'(ZQOPER_CYC - 1) : CNT_W'(ZQINIT_CYC - 1);
          first_nxt = 1'b1;
        end
        else if (cmd == ZQC_CMD_SHORT)
        begin
          st_nxt = ZQC_CAL;
          start_nxt = 1'b1;
          run_nxt = CNT_W'(ENG_SHORT_CYC);
          win_nxt = CNT_W'(ZQCS_CYC - 1);
        end
      end
      ZQC_CAL:
      begin
        win_nxt = win_r - 12'h001;
        if (eif.done)
          st_nxt = ZQC_XFER;
      end
      ZQC_XFER:
      begin
        win_nxt = win_r - 12'h001;
        io_nxt = eif.code;
        st_nxt = ZQC_WAIT;
      end
      ZQC_WAIT:
      begin
        win_nxt = win_r - 12'h001;
        if (win_r == '0)
          st_nxt = ZQC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ZQC_IDLE;
      win_r <= '0;
      first_r <= 1'b0;
      io_r <= IMP_RST;
      start_r <= 1'b0;
      run_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      win_r <= win_nxt;
      first_r <= first_nxt;
      io_r <= io_nxt;
      start_r <= start_nxt;
      run_r <= run_nxt;
    end
  end

  assign eif.start = start_r;
  assign eif.run_cyc = run_r;
  assign io_code = io_r;
  assign zq_current_en = eif.busy;
  assign cal_busy = (st_r != ZQC_IDLE);
  assign first_long_done = first_r;

  // ****************************************
  // window bounds and length tracking for checks
  // ****************************************
  localparam int INIT_LAST = ZQINIT_CYC - 1;
  localparam int OPER_LAST = ZQOPER_CYC - 1;
  localparam int SHORT_LAST = ZQCS_CYC - 1;

  logic [CNT_W-1:0] len_r, len_nxt;
  logic [CNT_W-1:0] exp_r, exp_nxt;

  // busy cycles counted from the accepting edge
  always_comb
  begin
    len_nxt = len_r;
    exp_nxt = exp_r;
    if (!cal_busy && cmd == ZQC_CMD_LONG)
    begin
      len_nxt = '0;
      exp_nxt = first_r ? CNT_W'(ZQOPER_CYC) : CNT_W'(ZQINIT_CYC);
    end
    else if (!cal_busy && cmd == ZQC_CMD_SHORT)
    begin
      len_nxt = '0;
      exp_nxt = CNT_W'(ZQCS_CYC);
    end
    else if (cal_busy)
      len_nxt = len_r + 12'h001;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      len_r <= '0;
      exp_r <= '0;
    end
    else
    begin
      len_r <= len_nxt;
      exp_r <= exp_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_long_cmd;
    st_r == ZQC_IDLE && cmd == ZQC_CMD_LONG;
  endsequence

  sequence s_xfer;
    st_r == ZQC_XFER ##1 io_r == $past(eif.code);
  endsequence

  AST_XFER_AFTER_DONE: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_CAL && eif.done |=> s_xfer)
    else $error("code not transferred after engine done");
  AST_FIRST_LONG: assert property (@(posedge core_clk) disable iff (rst)
    s_long_cmd and !first_r |=> ##[1:INIT_LAST] st_r == ZQC_WAIT)
    else $error("first long calibration late");
  AST_LATER_LONG: assert property (@(posedge core_clk) disable iff (rst)
    s_long_cmd and first_r |=> ##[1:OPER_LAST] st_r == ZQC_WAIT)
    else $error("long calibration late");
  AST_SHORT: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_IDLE && cmd == ZQC_CMD_SHORT |=> ##[1:SHORT_LAST] st_r == ZQC_WAIT)
    else $error("short calibration late");
  AST_WINDOW_LEN: assert property (@(posedge core_clk) disable iff (rst)
    $fell(cal_busy) |-> len_r == exp_r)
    else $error("calibration window length wrong");
  AST_REFUSED: assert property (@(posedge core_clk) disable iff (rst)
    st_r != ZQC_IDLE && cmd != ZQC_CMD_NONE |=> win_r == $past(win_r) - 12'h001)
    else $error("window restarted by a refused command");
  AST_ACCEPT: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_IDLE && cmd != ZQC_CMD_NONE |=> st_r == ZQC_CAL ##1 zq_current_en)
    else $error("calibration command not accepted");
  AST_CURRENT_OFF: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_WAIT |-> !zq_current_en)
    else $error("calibration current left on");
  AST_RELOCK: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_IDLE && dll_relock && cmd == ZQC_CMD_SHORT |=> cal_busy)
    else $error("calibration refused during relock");
  AST_NO_SELF_CAL: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ZQC_IDLE && sr_exit && cmd == ZQC_CMD_NONE |=> !cal_busy && $stable(io_code))
    else $error("calibration on self-refresh exit");

endmodule // zqc_seq

// ===== tb/test_zq_calibration_sequencing.sv
// testbench for the impedance calibration sequencer
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module test_zq_calibration_sequencing
  import zqc_pkg::*;
();
  localparam int WI = 32;
  localparam int WO = 16;
  localparam int WS = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic dll_relock = 1'b0;
  logic cmp_hi = 1'b1;
  logic sr_exit;
  zqc_cmd_t cmd;
  logic [IMP_W-1:0] io_code;
  logic zq_current_en;
  logic cal_busy;
  logic first_long_done;
  logic cke;
  logic odt;
  logic dq_oe;
  logic [IMP_W-1:0] code_keep;
  int errors = 0;
  int n_tests = 0;
  typedef struct {zqc_cmd_t c; logic rl; logic cp; int win;} zqc_row_t;
  zqc_row_t rows [5] = '{'{ZQC_CMD_LONG, 1'b0, 1'b1, WI}, '{ZQC_CMD_LONG, 1'b0, 1'b0, WO},
    '{ZQC_CMD_SHORT, 1'b0, 1'b1, WS}, '{ZQC_CMD_LONG, 1'b1, 1'b0, WO}, '{ZQC_CMD_SHORT, 1'b1, 1'b1, WS}};

  zqc_seq #(.ZQINIT_CYC(WI), .ZQOPER_CYC(WO), .ZQCS_CYC(WS), .ENG_LONG_CYC(8), .ENG_SHORT_CYC(4)) dut_u (
    .core_clk(core_clk), .rst(rst), .cmd(cmd), .dll_relock(dll_relock), .sr_exit(sr_exit),
    .cmp_hi(cmp_hi), .io_code(io_code), .zq_current_en(zq_current_en), .cal_busy(cal_busy),
    .first_long_done(first_long_done));

  zqc_ctrl_model ctl_u (.core_clk(core_clk), .cal_busy(cal_busy), .cmd(cmd), .sr_exit(sr_exit),
    .cke(cke), .odt(odt), .dq_oe(dq_oe));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one calibration, window length and result checked
  task automatic run(input zqc_cmd_t c, input logic rl, input logic cp, input int win);
    int n;
    int on;
    logic [IMP_W-1:0] c0;
    n = 0;
    on = 0;
    dll_relock <= rl;
    cmp_hi <= cp;
    c0 = io_code;
    ctl_u.send(c, 1'b1);
    #1;
    `CHK("busy_start", cal_busy, 1'b1)
    `CHK("cke_high", cke, 1'b1)
    `CHK("odt_low", odt, 1'b0)
    `CHK("dq_released", dq_oe, 1'b0)
    while (cal_busy === 1'b1 && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
      on += (zq_current_en === 1'b1);
    end
    `CHK("window", n, win)
    `CHK("current_off", zq_current_en, 1'b0)
    `CHK("current_ran", on > 0, 1'b1)
    `CHK("code_moved", cp ? io_code > c0 : io_code < c0, 1'b1)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK("rst_code", io_code, IMP_RST)
    `CHK("rst_busy", cal_busy, 1'b0)
    `CHK("rst_cur", zq_current_en, 1'b0)
    `CHK("rst_first", first_long_done, 1'b0)
    $display("reset test done");
    foreach (rows[i])
    begin
      run(rows[i].c, rows[i].rl, rows[i].cp, rows[i].win);
      `CHK("first_set", first_long_done, 1'b1)
    end
    $display("row tests done");
    fork
      run(ZQC_CMD_LONG, 1'b0, 1'b0, WO);
      begin
        repeat (4) @(posedge core_clk);
        ctl_u.send(ZQC_CMD_SHORT, 1'b0);
      end
    join
    $display("refused command test done");
    code_keep = io_code;
    ctl_u.srx();
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("srx_idle", cal_busy, 1'b0)
    `CHK("srx_cur", zq_current_en, 1'b0)
    `CHK("srx_code", io_code, code_keep)
    run(ZQC_CMD_SHORT, 1'b1, 1'b1, WS);
    $display("self refresh exit test done");
    ctl_u.send(ZQC_CMD_LONG, 1'b1);
    repeat (3) @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK("mid_busy", cal_busy, 1'b0)
    `CHK("mid_first", first_long_done, 1'b0)
    `CHK("mid_code", io_code, IMP_RST)
    run(ZQC_CMD_LONG, 1'b0, 1'b1, WI);
    $display("mid reset test done");
    results();
  end

  initial
  begin
    #400000;
    errors++;
    results();
  end
endmodule // test_zq_calibration_sequencing

// ===== tb/zqc_ctrl_model.sv
// controller model issuing calibration commands
`timescale 1ns/1ps
module zqc_ctrl_model
  import zqc_pkg::*;
#(
  parameter int TXS_CYC = 4
)
(
  // clock and status
  input wire logic core_clk,
  input wire logic cal_busy,
  // command side
  output zqc_cmd_t cmd,
  output logic sr_exit,
  // channel levels held during calibration
  output logic cke,
  output logic odt,
  output logic dq_oe
);
  int txs_r = 0;

  initial
  begin
    cmd = ZQC_CMD_NONE;
    sr_exit = 1'b0;
    cke = 1'b1;
    odt = 1'b0;
    dq_oe = 1'b0;
  end

  // exit delay counter, loaded by the exit pulse
  always @(posedge core_clk)
    if (sr_exit) txs_r <= TXS_CYC;
    else if (txs_r > 0) txs_r <= txs_r - 1;

  // quiet mode waits out the window and the exit delay
  task automatic send(input zqc_cmd_t c, input bit quiet);
    int n;
    n = 0;
    while (quiet && (cal_busy !== 1'b0 || txs_r > 0) && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd <= c;
    @(posedge core_clk);
    cmd <= ZQC_CMD_NONE;
  endtask

  task automatic srx();
    @(posedge core_clk);
    sr_exit <= 1'b1;
    @(posedge core_clk);
    sr_exit <= 1'b0;
  endtask
endmodule // zqc_ctrl_model
